// ---- src/ibcd_top.sv ----
`timescale 1ns/1ps
`include "ibcd_defines.svh"
module ibcd_top (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     scan_index,
	input  wire logic                     door_at_target,
	output logic      [7:0]               relay_primary,
	output logic      [7:0]               relay_redundant,
	output logic                          door_go,
	output ibcd_pkg::ibcd_door_e          door_sel,
	output logic      [1:0]               door_pos,
	output logic                          screen_open,
	output logic                          door_use_sensor,
	output logic                          event_pulse,
	output logic                          scan_tick,
	output logic                          telem_tick
);
	import ibcd_pkg::*;

	// ---------------------------------------------------------------
	// Timing constants
	// ---------------------------------------------------------------
	localparam int SCAN_CYC  = `IBCD_SCAN_US / 1000 * (`IBCD_CLK_HZ / 1000);
	localparam int MAJOR_CYC = `IBCD_MAJOR_US / 1000 * (`IBCD_CLK_HZ / 1000);
	localparam int PULSE_CYC = `IBCD_PULSE_US * (`IBCD_CLK_HZ / 1000000);

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	logic        [15:0] ptab [`IBCD_PTAB_DEPTH];
	logic        [15:0] cmd_word;
	logic        [15:0] prm_word;
	logic        [7:0]  relay_enable;
	logic        [7:0]  relay_dual;
	logic        [15:0] event_count;
	logic        [15:0] last_event_cmd;
	logic               macro_active;
	logic               macro_aborted;
	logic               scan_stopped;
	logic        [2:0]  scan_sync;
	logic               scan_level;
	logic        [31:0] scan_cnt;
	logic        [31:0] major_cnt;
	logic        [15:0] pulse_cnt;
	ibcd_state_e        state;

	wire acc      = psel & penable;
	wire wr       = acc & pwrite;
	wire hit_cmd  = paddr == `IBCD_OFF_CMD;
	wire hit_prm  = paddr == `IBCD_OFF_PARAM;
	wire hit_sta  = paddr == `IBCD_OFF_STATUS;
	wire hit_en   = paddr == `IBCD_OFF_ENABLE;
	wire hit_dual = paddr == `IBCD_OFF_DUAL;
	wire hit_evt  = paddr == `IBCD_OFF_EVENT;
	wire hit_door = paddr == `IBCD_OFF_DOOR;
	wire hit_misc = paddr == `IBCD_OFF_MISC;
	wire hit_ptab = paddr[11:5] == 7'(`IBCD_OFF_PTAB >> 5);
	wire [2:0] ptab_idx = paddr[4:2];
	wire mapped   = hit_cmd | hit_prm | hit_sta | hit_en | hit_dual | hit_evt | hit_door | hit_misc | hit_ptab;

	// Writing the command register submits a command; it is dropped unless the machine is idle.
	wire submit   = wr & hit_cmd & (state == ibcd_st_idle);

	// ---------------------------------------------------------------
	// Command field split
	// ---------------------------------------------------------------
	// Bus bit 15 is word bit 0, so the MSB-first numbering maps straight onto it.
	wire [4:0] opc = cmd_word[`IBCD_OPC_HI:`IBCD_OPC_LO];
	wire [2:0] wc  = cmd_word[`IBCD_WC_HI:`IBCD_WC_LO];
	wire [7:0] prm = cmd_word[`IBCD_PRM_HI:`IBCD_PRM_LO];
	wire [1:0] door_select_field   = cmd_word[7:6];
	wire [3:0] door_zero_bits      = cmd_word[5:2];
	wire [1:0] door_position_field = cmd_word[1:0];

	// ---------------------------------------------------------------
	// Validity
	// ---------------------------------------------------------------
	wire is_relay = opc == `IBCD_OPC_RELAY;
	wire is_set   = opc == `IBCD_OPC_SETPRM;
	wire is_door  = opc == `IBCD_OPC_DOOR;
	wire is_macro = opc == `IBCD_OPC_MACRO;
	wire is_mem   = (opc == `IBCD_OPC_MEMLD) | (opc == `IBCD_OPC_MEMDP);
	wire relay_ok = is_relay & (wc == 3'h0) & (prm < 8'(`IBCD_RELAY_IDS));
	wire set_ok   = is_set & (wc == 3'h1) & (prm < 8'(`IBCD_PTAB_DEPTH));
	wire door_leg = (door_position_field == 2'(ibcd_pos_screen)) ? (door_select_field == 2'(ibcd_door_diff)) :
	                (door_position_field == 2'(ibcd_pos_outgas)) ? (door_select_field == 2'(ibcd_door_space)) :
	                1'b1;
	wire door_ok  = is_door & (wc == 3'h0) & (door_select_field != 2'h0) & (door_zero_bits == 4'h0) &
	                door_leg;
	// Nested macros are refused; memory blocks are limited by length in low bits.
	wire macro_ok = is_macro & !macro_active;
	wire mem_ok   = is_mem & ({1'b0, prm[5:0]} <= 7'(`IBCD_MEM_MAX)) & (prm[5:0] != 6'h0);
	wire cmd_ok   = relay_ok | set_ok | door_ok | macro_ok | mem_ok;
	wire inhibited = relay_ok & !relay_enable[prm[2:0]];

	// ---------------------------------------------------------------
	// Command state machine
	// ---------------------------------------------------------------
	ibcd_state_e next_state;
	always_comb begin
		next_state = state;
		case (state)
			ibcd_st_idle: if (submit) next_state = ibcd_st_exec;
			ibcd_st_exec: next_state = ibcd_st_done;
			ibcd_st_done: if (pulse_cnt == 16'h0000) next_state = ibcd_st_idle;
			default: next_state = ibcd_st_idle;
		endcase
	end

	// State and captured command.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= ibcd_st_idle;
			cmd_word <= 16'h0000;
		end else begin
			state <= next_state;
			if (submit)
				cmd_word <= pwdata[15:0];
		end
	end

	// Macro tracking: a bad step ends the whole macro. Hardware events beat a
	// software clear in the same cycle, so an abort is never lost.
	wire macro_start = (state == ibcd_st_exec) & is_macro & macro_ok;
	wire macro_kill  = (state == ibcd_st_exec) & macro_active & !cmd_ok;
	wire misc_wr     = wr & hit_misc;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			macro_active  <= 1'b0;
			macro_aborted <= 1'b0;
		end else begin
			if (macro_start)
				macro_active <= 1'b1;
			else if (macro_kill)
				macro_active <= 1'b0;
			else if (misc_wr & pwdata[0])
				macro_active <= 1'b0;
			if (macro_kill)
				macro_aborted <= 1'b1;
			else if (misc_wr & pwdata[1])
				macro_aborted <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Execution: relays, table, door
	// ---------------------------------------------------------------
	wire exec = (state == ibcd_st_exec) & cmd_ok;
	wire [7:0] relay_bit = 8'h01 << prm[2:0];

	// Relay pulses last a fixed width; low level commands ignore instrument state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_primary   <= 8'h00;
			relay_redundant <= 8'h00;
			pulse_cnt       <= 16'h0000;
		end else if (exec & relay_ok & !inhibited) begin
			relay_primary   <= relay_bit;
			relay_redundant <= relay_dual[prm[2:0]] ? relay_bit : 8'h00;
			pulse_cnt       <= 16'(PULSE_CYC);
		end else if (pulse_cnt != 16'h0000) begin
			pulse_cnt <= pulse_cnt - 16'h0001;
		end else begin
			relay_primary   <= 8'h00;
			relay_redundant <= 8'h00;
		end
	end

	// Table write touches exactly one entry.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `IBCD_PTAB_DEPTH; i++)
				ptab[i] <= 16'h0000;
		end else if (exec & set_ok) begin
			ptab[prm[2:0]] <= prm_word;
		end
	end

	// Door request; the sensor is preferred except for space-door outgas.
	wire diff_open = (door_select_field == 2'(ibcd_door_diff)) & (door_position_field == 2'(ibcd_pos_open));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			door_go         <= 1'b0;
			door_sel        <= ibcd_door_none;
			door_pos        <= 2'h0;
			screen_open     <= 1'b0;
			door_use_sensor <= 1'b0;
		end else if (exec & door_ok) begin
			door_go         <= 1'b1;
			door_sel        <= ibcd_door_e'(door_select_field);
			door_pos        <= door_position_field;
			screen_open     <= diff_open;
			door_use_sensor <= !(door_position_field == 2'(ibcd_pos_outgas));
		end else if (door_at_target) begin
			door_go <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Events
	// ---------------------------------------------------------------
	// Invalid or inhibited commands count as events; apart from an invalid step ending an active macro, nothing else happens.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_pulse    <= 1'b0;
			event_count    <= 16'h0000;
			last_event_cmd <= 16'h0000;
		end else begin
			event_pulse <= (state == ibcd_st_exec) & (!cmd_ok | inhibited);
			if ((state == ibcd_st_exec) & (!cmd_ok | inhibited)) begin
				event_count    <= event_count + 16'h0001;
				last_event_cmd <= cmd_word;
			end else if (wr & hit_evt)
				event_count <= 16'h0000;
		end
	end

	// ---------------------------------------------------------------
	// Scan and telemetry ticks
	// ---------------------------------------------------------------
	// A new index level counts only once the last two stages agree, which filters
	// a glitch that lasts a single cycle; the settled level resets to the idle pin level.
	wire scan_agree = scan_sync[1] == scan_sync[2];
	wire scan_edge  = scan_agree & scan_sync[2] & !scan_level;
	// The substitute cycle runs whenever software says the mirror is stopped.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_sync  <= 3'h0;
			scan_level <= 1'b0;
			scan_cnt   <= 32'h0000_0000;
			scan_tick  <= 1'b0;
		end else begin
			scan_sync <= {scan_sync[1:0], scan_index};
			if (scan_agree)
				scan_level <= scan_sync[2];
			scan_tick <= 1'b0;
			if (scan_stopped) begin
				if (scan_cnt >= 32'(SCAN_CYC - 1)) begin
					scan_cnt  <= 32'h0000_0000;
					scan_tick <= 1'b1;
				end else
					scan_cnt <= scan_cnt + 32'h0000_0001;
			end else if (scan_edge)
				scan_tick <= 1'b1;
		end
	end

	// Major cycle tick for telemetry framing.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			major_cnt  <= 32'h0000_0000;
			telem_tick <= 1'b0;
		end else if (major_cnt >= 32'(MAJOR_CYC - 1)) begin
			major_cnt  <= 32'h0000_0000;
			telem_tick <= 1'b1;
		end else begin
			major_cnt  <= major_cnt + 32'h0000_0001;
			telem_tick <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	// Irreversible relays power up inhibited.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_enable <= 8'h00;
			relay_dual   <= 8'h00;
			prm_word     <= 16'h0000;
			scan_stopped <= 1'b0;
		end else begin
			if (wr & hit_en)
				relay_enable <= pwdata[7:0];
			if (wr & hit_dual)
				relay_dual <= pwdata[7:0];
			if (wr & hit_prm)
				prm_word <= pwdata[15:0];
			if (wr & hit_misc)
				scan_stopped <= pwdata[2];
		end
	end

	// ---------------------------------------------------------------
	// APB read path
	// ---------------------------------------------------------------
	// Every mapped address answers; unmapped ones flag an error.
	wire [31:0] rd_mux =
		hit_cmd  ? {16'h0000, cmd_word} :
		hit_prm  ? {16'h0000, prm_word} :
		hit_sta  ? {28'h000_0000, macro_aborted, macro_active, 2'(state)} :
		hit_en   ? {24'h00_0000, relay_enable} :
		hit_dual ? {24'h00_0000, relay_dual} :
		hit_evt  ? {last_event_cmd, event_count} :
		hit_door ? {27'h000_0000, door_use_sensor, door_go, 2'(door_sel), screen_open} :
		hit_misc ? {29'h0000_0000, scan_stopped, macro_aborted, macro_active} :
		hit_ptab ? {16'h0000, ptab[ptab_idx]} : 32'h0000_0000;

	// No wait states: setup, then access answered on the first access edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & !penable;
			pslverr <= psel & !penable & !mapped;
			prdata  <= (psel & !penable & !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	bad_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ibcd_st_exec) & !cmd_ok |=> $stable(ptab[0]) && !$rose(door_go) && (relay_primary == 8'h00))
		else $error("invalid command changed state");
	inhib_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ibcd_st_exec) & inhibited |=> event_pulse)
		else $error("inhibited relay raised no event");
	dual_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
		exec & relay_ok & !inhibited & relay_dual[prm[2:0]] |=> relay_redundant == relay_primary)
		else $error("dual relay not fired on both drivers");
	relay_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
		exec & relay_ok & !inhibited |=> relay_primary != 8'h00)
		else $error("relay pulse missing");
	door_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		door_go |-> door_sel != ibcd_door_none)
		else $error("door moved with select zero");
	screen_a: assert property (@(posedge pclk) disable iff (!presetn)
		exec & door_ok & (door_select_field == 2'h3) & (door_position_field == 2'h1) |=> screen_open)
		else $error("diffuser open without screen");
	legal_a: assert property (@(posedge pclk) disable iff (!presetn)
		door_go |-> ((door_pos != 2'h2) || (door_sel == ibcd_door_diff)) &&
		((door_pos != 2'h3) || (door_sel == ibcd_door_space)))
		else $error("screen position on wrong door");
	macro_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ibcd_st_exec) & macro_active & !cmd_ok |=> !macro_active & macro_aborted)
		else $error("macro not aborted");
	table_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		exec & set_ok & (prm[2:0] == 3'h0) |=> ptab[0] == $past(prm_word))
		else $error("table entry not written");
	c_relay_c: cover property (@(posedge pclk) exec & relay_ok & !inhibited);
	c_door_c: cover property (@(posedge pclk) exec & door_ok);
	c_bad_c: cover property (@(posedge pclk) event_pulse);
	c_abort_c: cover property (@(posedge pclk) $rose(macro_aborted));
endmodule

// ---- src/ibcd_defines.svh ----
`ifndef IBCD_DEFINES_SVH
`define IBCD_DEFINES_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define IBCD_OFF_CMD       12'h000
`define IBCD_OFF_PARAM     12'h004
`define IBCD_OFF_STATUS    12'h008
`define IBCD_OFF_ENABLE    12'h00C
`define IBCD_OFF_DUAL      12'h010
`define IBCD_OFF_EVENT     12'h014
`define IBCD_OFF_PTAB      12'h020
`define IBCD_OFF_DOOR      12'h018
`define IBCD_OFF_MISC      12'h01C

// ---------------------------------------------------------------
// Command word fields (bit 0 is the word MSB, bit 15 of the bus)
// ---------------------------------------------------------------
`define IBCD_OPC_HI        15
`define IBCD_OPC_LO        11
`define IBCD_WC_HI         10
`define IBCD_WC_LO         8
`define IBCD_PRM_HI        7
`define IBCD_PRM_LO        0
`define IBCD_OPC_RELAY     5'h03
`define IBCD_OPC_SETPRM    5'h0C
`define IBCD_OPC_DOOR      5'h1F
`define IBCD_OPC_MACRO     5'h1C
`define IBCD_OPC_MEMLD     5'h1A
`define IBCD_OPC_MEMDP     5'h1B
`define IBCD_MEM_MAX       6'h20

// ---------------------------------------------------------------
// Table sizes and timing
// ---------------------------------------------------------------
`define IBCD_PTAB_DEPTH    8
`define IBCD_RELAY_IDS     8
`define IBCD_CLK_HZ        20000000
`define IBCD_SCAN_US       1477000
`define IBCD_MAJOR_US      1024000
`define IBCD_PULSE_US      10

`endif

// ---- src/ibcd_pkg.sv ----
package ibcd_pkg;
	typedef enum logic [1:0] {
		ibcd_door_none, ibcd_door_nadir, ibcd_door_space, ibcd_door_diff
	} ibcd_door_e;
	typedef enum logic [1:0] {
		ibcd_pos_closed, ibcd_pos_open, ibcd_pos_screen, ibcd_pos_outgas
	} ibcd_pos_e;
	typedef enum logic [1:0] {ibcd_st_idle, ibcd_st_exec, ibcd_st_done} ibcd_state_e;
endpackage

// ---- dv/ibcd_bus_ctrl.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Command source model: issues command and register traffic as APB
// ---------------------------------------------------------------
module ibcd_bus_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic timed_out;

	// Idle bus at time zero so the block never sees an unknown request.
	initial begin
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 12'h000;
		pwdata    = 32'h0000_0000;
		timed_out = 1'b0;
	end

	// One transfer, entered right after a rising edge. The request is held until
	// pready is seen high; released lines show the inverse so stale data is not
	// mistaken for a live value. Power-sensitive spacing is left to the caller,
	// since a three second gap does not fit a short run.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		timed_out = (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a;
		pwdata  <= ~d;
		@(posedge pclk);
	endtask
endmodule

// ---- dv/test_instrument_bus_command_decoder.sv ----
`timescale 1ns/1ps
module test_instrument_bus_command_decoder;
	import ibcd_pkg::*;
	logic        pclk, presetn, scan_index, door_at_target, err;
	logic        psel, penable, pwrite, pready, pslverr;
	logic        door_go, door_use_sensor, screen_open, event_pulse, scan_tick, telem_tick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [7:0]  relay_primary, relay_redundant, pri_seen, red_seen;
	logic [1:0]  door_pos;
	logic [5:0]  door_seen;
	ibcd_door_e  door_sel;
	int          num_errors, compares, ev_cnt, go_cnt, sc_cnt, tl_cnt, en, dual, v, ptab[8];

	ibcd_top ibcd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scan_index(scan_index), .door_at_target(door_at_target),
		.relay_primary(relay_primary), .relay_redundant(relay_redundant), .door_go(door_go),
		.door_sel(door_sel), .door_pos(door_pos), .screen_open(screen_open),
		.door_use_sensor(door_use_sensor), .event_pulse(event_pulse), .scan_tick(scan_tick),
		.telem_tick(telem_tick));
	ibcd_bus_ctrl ibcd_bus_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// ---------------------------------------------------------------
	// Clock and output monitor
	// ---------------------------------------------------------------
	always #25 pclk = ~pclk;

	// Pulses are collected every edge, so a one-cycle pulse is never missed.
	always @(posedge pclk) begin
		if (event_pulse === 1'b1) ev_cnt++;
		if (door_go === 1'b1 && go_cnt == 0) door_seen = {door_use_sensor, screen_open, door_sel, door_pos};
		if (door_go === 1'b1) go_cnt++;
		if (scan_tick === 1'b1) sc_cnt++;
		if (telem_tick !== 1'b0) tl_cnt++;
		pri_seen |= relay_primary;
		red_seen |= relay_redundant;
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		ibcd_bus_ctrl_i.xfer(w, a, d, rd, err);
		if (ibcd_bus_ctrl_i.timed_out) begin
			num_errors++;
			print_verdict();
		end
	endtask

	// Issues one command, lets the door logic report arrival, then polls for idle,
	// because a command written while busy would be dropped silently.
	task automatic send(input logic [31:0] w);
		int n;
		@(negedge pclk);
		ev_cnt = 0;
		go_cnt = 0;
		pri_seen = 8'h00;
		red_seen = 8'h00;
		@(posedge pclk);
		bus(1'b1, 12'h000, w);
		repeat (3) @(posedge pclk);
		door_at_target <= 1'b1;
		@(posedge pclk);
		door_at_target <= 1'b0;
		n = 0;
		do begin
			bus(1'b0, 12'h008, 32'h0000_0000);
			n++;
		end while (rd[1:0] !== 2'b00 && n < 100);
		if (rd[1:0] !== 2'b00) begin
			num_errors++;
			print_verdict();
		end
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		scan_index = 1'b0;
		door_at_target = 1'b0;
		seed = 32'h920f_2f00;
		en = 32'h0000_0006;
		dual = 32'h0000_0004;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		bus(1'b0, 12'h008, 32'h0000_0000);
		check("status reset", rd, 32'h0000_0000);
		bus(1'b0, 12'h00C, 32'h0000_0000);
		check("enable reset", rd, 32'h0000_0000);
		bus(1'b0, 12'h040, 32'h0000_0000);
		check("unmapped err", {31'h0, err}, 32'h0000_0001);
		check("unmapped data", rd, 32'h0000_0000);
		// Relay while every irreversible relay is still inhibited.
		send(32'h0000_1802);
		check("inhibited pulse", {24'h0, pri_seen}, 32'h0000_0000);
		check("inhibited event", ev_cnt, 1);
		bus(1'b1, 12'h00C, en);
		bus(1'b1, 12'h010, dual);
		// Every relay id plus one beyond the table; opcode leads, count is zero.
		for (int id = 0; id < 9; id++) begin
			v = (id < 8) ? en[id] : 0;
			send(32'h0000_1800 | id);
			check("relay primary", {24'h0, pri_seen}, v ? (32'h1 << id) : 0);
			check("relay redundant", {24'h0, red_seen}, (v && dual[id]) ? (32'h1 << id) : 0);
			check("relay event", ev_cnt, !v);
		end
		send(32'h0000_1901);
		check("count mismatch", ev_cnt + pri_seen, 1);
		// Set-parameter: index in the low byte, value from the parameter register.
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			ptab[i] = seed[15:0];
			bus(1'b1, 12'h004, seed);
			send(32'h0000_6100 | i);
			check("setprm event", ev_cnt, 0);
		end
		bus(1'b1, 12'h004, ~seed);
		send(32'h0000_6003);
		check("setprm bad count", ev_cnt, 1);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, 12'h020 + 12'(4 * i), 32'h0000_0000);
			check("ptab entry", rd[15:0], ptab[i]);
		end
		// Every door select and position pairing.
		for (int sel = 0; sel < 4; sel++) begin
			for (int pos = 0; pos < 4; pos++) begin
				v = sel != 0 && !(pos == 2 && sel != 3) && !(pos == 3 && sel != 2);
				send(32'h0000_F800 | (sel << 6) | pos);
				check("door event", ev_cnt, !v);
				check("door go", go_cnt != 0, v);
				if (v) check("door fields", door_seen, {!(sel == 2 && pos == 3), sel == 3 && pos == 1,
					2'(sel), 2'(pos)});
			end
		end
		send(32'h0000_F845);
		check("door zero bits", ev_cnt + go_cnt, 1);
		// Memory block lengths at and beyond the limit, load and dump.
		for (int op = 0; op < 2; op++) begin
			for (int k = 0; k < 4; k++) begin
				v = (k == 0) ? 0 : (k == 1) ? 1 : (k == 2) ? 32 : 33;
				send(32'h0000_D000 | (op << 11) | v);
				check("mem length", ev_cnt, v == 0 || v > 32);
			end
		end
		// Macro start, then a bad step inside it aborts the macro.
		send(32'h0000_E000);
		check("macro event", ev_cnt, 0);
		bus(1'b0, 12'h008, 32'h0000_0000);
		check("macro active", rd[2], 1'b1);
		send(32'h0001_1901);
		check("macro bad step", ev_cnt, 1);
		bus(1'b0, 12'h008, 32'h0000_0000);
		check("macro aborted", rd[3], 1'b1);
		bus(1'b1, 12'h01C, 32'h0000_0003);
		bus(1'b0, 12'h008, 32'h0000_0000);
		check("status cleared", rd[3:0], 4'h0);
		// One index pulse gives one scan tick; its fall gives none.
		sc_cnt = 0;
		scan_index <= 1'b1;
		repeat (8) @(posedge pclk);
		check("scan tick", sc_cnt, 1);
		scan_index <= 1'b0;
		repeat (8) @(posedge pclk);
		check("scan tick once", sc_cnt, 1);
		// The major cycle is far longer than this run, so no telemetry tick may appear.
		check("telem tick", tl_cnt, 0);
		print_verdict();
	end
endmodule
